/* File: tcc_pkg.sv */
// package: constants, types and carriers for the 8-bit capture/compare timer
package tcc_pkg;

  localparam int         TCC_W          = 8;
  localparam logic [7:0] TCC_CNT_RESET  = 8'hFC;
  localparam logic [7:0] TCC_CMP_RESET  = 8'h00;
  localparam logic [7:0] TCC_CNT_MAX    = 8'hFF;
  localparam logic [7:0] TCC_ONE        = 8'h01;

  // prescaler factors
  localparam int TCC_DIV2    = 2;
  localparam int TCC_DIV4    = 4;
  localparam int TCC_DIV8    = 8;
  localparam int TCC_DIV8000 = 8000;
  localparam int TCC_PRE_W   = 13;

  // clock select encodings
  localparam logic [1:0] TCC_CS_DIV4    = 2'h0;
  localparam logic [1:0] TCC_CS_DIV2    = 2'h1;
  localparam logic [1:0] TCC_CS_DIV8    = 2'h2;
  localparam logic [1:0] TCC_CS_DIV8000 = 2'h3;

  // software control bits
  typedef struct packed {
    logic [1:0] clock_select_field;
    logic       overflow_irq_enable;
    logic       capture_irq_enable;
    logic       compare_irq_enable;
    logic [1:0] capture_edge_select;   // [0] channel one, [1] channel two
    logic [1:0] compare_pin_enable;
    logic [1:0] output_level;
    logic       single_pulse_mode;
    logic       pwm_mode;
  } tcc_ctrl_t;

  // one-cycle access strobes from the cpu register logic
  typedef struct packed {
    logic       status_read;
    logic       main_count_access;
    logic       main_count_write;
    logic       alt_count_write;
    logic [1:0] capture_value_access;
    logic [1:0] compare_value_access;
    logic [1:0] compare_value_write;
    logic [1:0] force_output_write;
  } tcc_acc_t;

  typedef struct packed {
    logic       overflow_flag;
    logic [1:0] capture_flag;
    logic [1:0] compare_flag;
  } tcc_flags_t;

endpackage : tcc_pkg

/* File: tcc_core.sv */
// module: 8-bit free-running timer with two capture and two compare channels
`timescale 1ns/1ps
// What this block does
// - 8-bit up-counter advances once per prescaled tick, free running
// - counter loads FCh at reset and on any main or alternate count write
// - prescaler divides by 2, 4, 8 or 8000 per clock select field
// - overflow flag sets on FFh to 00h wrap in every mode
// - overflow irq only with enable set and cpu mask clear; else pending
// - overflow flag clears after status read then main count access
// - alternate count access never clears the overflow flag
// - counter keeps running in wait mode
// - halt stops counter; resumes from held count, reset restarts at reset count
// - active capture edge latches counter into capture value i
// - each capture channel has its own edge select bit
// - capture sets flag i; shared enable raises irq when mask clear
// - capture flag clears on status read then capture value i access
// - each new capture overwrites capture value i
// - capture inputs always connected; only the selected edge triggers capture (select bit 1 rising, 0 falling)
// - in single pulse or pwm mode only capture channel two captures
// - compare values compared each tick, untouched by hardware, reset 00h
// - match sets compare flag i and drives enabled pin with level bit
// - compare match raises irq with shared enable and mask clear
// - compare flag clears on status read then compare value i access
// - pin enable clear: pin not driven on match, flag and irq still work
// - div2 matches at count equal compare, other rates at compare plus 1
// - force bit copies level to enabled pin, no flag, no irq
// - force bits ignored in single pulse and pwm modes
module tcc_core
  import tcc_pkg::*;
#(
  parameter int SLOW_DIV = TCC_DIV8000
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire tcc_ctrl_t         ctrl,
  input  wire tcc_acc_t          acc,
  input  wire logic [TCC_W-1:0]  compare_wdata,
  input  wire logic              osc_tick,
  input  wire logic              cpu_irq_mask,
  input  wire logic              halt_mode,
  input  wire logic              wait_mode,
  input  wire logic              capture_input_one,
  input  wire logic              capture_input_two,
  output logic [TCC_W-1:0]       main_count_register,
  output logic [TCC_W-1:0]       alternate_count_register,
  output logic [TCC_W-1:0]       capture_value_one,
  output logic [TCC_W-1:0]       capture_value_two,
  output logic [TCC_W-1:0]       compare_value_one,
  output logic [TCC_W-1:0]       compare_value_two,
  output tcc_flags_t             timer_status_register,
  output logic                   compare_output_one,
  output logic                   compare_output_two,
  output logic [1:0]             compare_output_drive,
  output logic                   timer_irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [TCC_PRE_W-1:0] pre;
    logic [TCC_W-1:0]     cnt;
    logic [1:0]           cap_s1;
    logic [1:0]           cap_s2;
    logic [1:0]           cap_prev;
    logic [1:0][TCC_W-1:0] cap_val;
    logic [1:0][TCC_W-1:0] cmp_val;
    logic [1:0]           pin;
    tcc_flags_t           flags;
    tcc_flags_t           armed;    // status read seen while flag set
    logic [2:0]           warm;     // sync stages filled since reset
  } tcc_state_t;

  tcc_state_t st_q;
  tcc_state_t st_d;

  logic                 tick;
  logic [TCC_PRE_W-1:0] div_sel;
  logic [TCC_W-1:0]     match_val;
  logic [1:0]           cap_hit;
  logic [1:0]           cmp_hit;
  logic                 special_mode;
  logic [1:0]           cap_in;
  logic [1:0]           edge_rise;
  logic [1:0]           edge_fall;
  logic                 cnt_load;
  logic [TCC_W-1:0]     cnt_next;

  assign cap_in       = {capture_input_two, capture_input_one};
  assign special_mode = ctrl.single_pulse_mode | ctrl.pwm_mode;
  // wait_mode has no effect; only halt freezes the prescaler and counter
  assign cnt_load     = acc.main_count_write | acc.alt_count_write;
  // next count, shared by the counter and the compare match
  assign cnt_next     = st_q.cnt + TCC_ONE;

  // ==========================================================
  // prescaler selection
  always_comb
  begin
    case (ctrl.clock_select_field)
      TCC_CS_DIV4:    div_sel = TCC_PRE_W'(TCC_DIV4);
      TCC_CS_DIV2:    div_sel = TCC_PRE_W'(TCC_DIV2);
      TCC_CS_DIV8:    div_sel = TCC_PRE_W'(TCC_DIV8);
      default:        div_sel = TCC_PRE_W'(SLOW_DIV);
    endcase
  end

  // slow rate counts oscillator ticks, the others count cpu clocks;
  // >= so that a rate change with a larger count left over cannot stall
  assign tick = !halt_mode && (st_q.pre >= div_sel - TCC_PRE_W'(1)) &&
                ((ctrl.clock_select_field != TCC_CS_DIV8000) || osc_tick);

  // div2 compares against count itself; slower rates one count later
  assign match_val = (ctrl.clock_select_field == TCC_CS_DIV2) ? TCC_W'(0) : TCC_ONE;

  // edges: second sync stage against its own delayed copy; masked until the
  // stages hold real pin levels, else a pin idling high fakes an edge after reset
  assign edge_rise = st_q.cap_s2 & ~st_q.cap_prev & {2{st_q.warm[2]}};
  assign edge_fall = ~st_q.cap_s2 & st_q.cap_prev & {2{st_q.warm[2]}};

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    cap_hit = '0;
    cmp_hit = '0;

    // prescaler advance
    if (!halt_mode && (ctrl.clock_select_field != TCC_CS_DIV8000 || osc_tick))
    begin
      st_d.pre = tick ? '0 : st_q.pre + TCC_PRE_W'(1);
    end

    // input synchronisers, first stage read only by second
    st_d.cap_s1   = cap_in;
    st_d.cap_s2   = st_q.cap_s1;
    st_d.cap_prev = st_q.cap_s2;
    st_d.warm     = {st_q.warm[1:0], 1'b1};

    // counter
    if (cnt_load)
    begin
      st_d.cnt = TCC_CNT_RESET;
      st_d.pre = '0;
    end
    else if (tick)
    begin
      st_d.cnt = cnt_next;
    end

    // flag clearing sequences: arm on status read, clear on next access
    if (acc.status_read)
    begin
      st_d.armed = st_q.flags;
    end
    if (acc.main_count_access && st_q.armed.overflow_flag)
    begin
      st_d.flags.overflow_flag = 1'b0;
      st_d.armed.overflow_flag = 1'b0;
    end

    for (int i = 0; i < 2; i++)
    begin
      if (acc.capture_value_access[i] && st_q.armed.capture_flag[i])
      begin
        st_d.flags.capture_flag[i] = 1'b0;
        st_d.armed.capture_flag[i] = 1'b0;
      end
      if (acc.compare_value_access[i] && st_q.armed.compare_flag[i])
      begin
        st_d.flags.compare_flag[i] = 1'b0;
        st_d.armed.compare_flag[i] = 1'b0;
      end

      // compare value storage, hardware never alters it
      if (acc.compare_value_write[i])
      begin
        st_d.cmp_val[i] = compare_wdata;
      end

      // capture: only the edge picked by capture_edge_select counts, 1 rising, 0 falling
      cap_hit[i] = ctrl.capture_edge_select[i] ? edge_rise[i] : edge_fall[i];
      if (i == 0 && special_mode)
      begin
        cap_hit[i] = 1'b0;
      end
      if (cap_hit[i])
      begin
        st_d.cap_val[i] = st_q.cnt;
        st_d.flags.capture_flag[i] = 1'b1;
      end

      // match on the count this tick loads, so flag and pin move with the count
      cmp_hit[i] = tick && !cnt_load && (cnt_next == st_q.cmp_val[i] + match_val);
      if (cmp_hit[i])
      begin
        st_d.flags.compare_flag[i] = 1'b1;
        if (ctrl.compare_pin_enable[i])
        begin
          st_d.pin[i] = ctrl.output_level[i];
        end
      end

      // forced output: level to pin only, flags untouched
      if (acc.force_output_write[i] && !special_mode && ctrl.compare_pin_enable[i])
      begin
        st_d.pin[i] = ctrl.output_level[i];
      end
    end

    // overflow; set wins over a same-cycle clear
    if (tick && !cnt_load && st_q.cnt == TCC_CNT_MAX)
    begin
      st_d.flags.overflow_flag = 1'b1;
    end
  end

  // ==========================================================
  // state register; pin latch held low in reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q          <= '0;
      st_q.cnt      <= TCC_CNT_RESET;
      st_q.cmp_val  <= {TCC_CMP_RESET, TCC_CMP_RESET};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign main_count_register      = st_q.cnt;
  assign alternate_count_register = st_q.cnt;
  assign capture_value_one        = st_q.cap_val[0];
  assign capture_value_two        = st_q.cap_val[1];
  assign compare_value_one        = st_q.cmp_val[0];
  assign compare_value_two        = st_q.cmp_val[1];
  assign timer_status_register    = st_q.flags;
  assign compare_output_one       = st_q.pin[0];
  assign compare_output_two       = st_q.pin[1];
  // pins stay general io when the channel enable is clear
  assign compare_output_drive     = ctrl.compare_pin_enable;

  // pending flags raise the line once the mask opens
  assign timer_irq = !cpu_irq_mask && (
                     (ctrl.overflow_irq_enable && st_q.flags.overflow_flag) ||
                     (ctrl.capture_irq_enable && |st_q.flags.capture_flag) ||
                     (ctrl.compare_irq_enable && |st_q.flags.compare_flag));

  // ==========================================================
  // checks
  chk_cnt_load_value: assert property (@(posedge clk) disable iff (rst)
    cnt_load |=> main_count_register == TCC_CNT_RESET)
    else $error("counter not reloaded after write");

  chk_overflow_set: assert property (@(posedge clk) disable iff (rst)
    (tick && !cnt_load && st_q.cnt == TCC_CNT_MAX) |=> st_q.flags.overflow_flag && st_q.cnt == 8'h00)
    else $error("overflow flag not set on wrap");

  chk_alt_no_clear: assert property (@(posedge clk) disable iff (rst)
    (st_q.flags.overflow_flag && !acc.main_count_access) |=> st_q.flags.overflow_flag)
    else $error("overflow flag lost without main count access");

  chk_halt_freeze: assert property (@(posedge clk) disable iff (rst)
    (halt_mode && !cnt_load) |=> $stable(st_q.cnt))
    else $error("counter moved in halt");

  chk_capture_latch: assert property (@(posedge clk) disable iff (rst)
    cap_hit[1] |=> capture_value_two == $past(st_q.cnt) && st_q.flags.capture_flag[1])
    else $error("capture two not latched");

  chk_capture_mode: assert property (@(posedge clk) disable iff (rst)
    special_mode |-> !cap_hit[0])
    else $error("capture one active in special mode");

  chk_compare_pin: assert property (@(posedge clk) disable iff (rst)
    (cmp_hit[0] && ctrl.compare_pin_enable[0] && !acc.force_output_write[0])
      |=> compare_output_one == $past(ctrl.output_level[0]) && st_q.flags.compare_flag[0])
    else $error("compare one pin or flag wrong");

  chk_irq_mask: assert property (@(posedge clk) disable iff (rst)
    cpu_irq_mask |-> !timer_irq)
    else $error("irq raised while masked");

  chk_compare_clear: assert property (@(posedge clk) disable iff (rst)
    (acc.compare_value_access[1] && st_q.armed.compare_flag[1] && !cmp_hit[1])
      |=> !st_q.flags.compare_flag[1])
    else $error("compare two flag not cleared");

  chk_compare_timing: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.flags.compare_flag[1])
      |-> st_q.cnt == TCC_W'($past(st_q.cmp_val[1]) + $past(match_val)))
    else $error("compare two flag rose at the wrong count");

  chk_force_no_flag: assert property (@(posedge clk) disable iff (rst)
    (acc.force_output_write[0] && !cmp_hit[0] && !st_q.flags.compare_flag[0])
      |=> !st_q.flags.compare_flag[0])
    else $error("forced output set compare one flag");

  chk_force_blocked: assert property (@(posedge clk) disable iff (rst)
    (acc.force_output_write[0] && special_mode && !cmp_hit[0])
      |=> $stable(compare_output_one))
    else $error("forced output acted in pulse or pwm mode");

  chk_irq_pending: assert property (@(posedge clk) disable iff (rst)
    (ctrl.overflow_irq_enable && st_q.flags.overflow_flag && !cpu_irq_mask) |-> timer_irq)
    else $error("pending overflow irq not raised");

  chk_capture_clear: assert property (@(posedge clk) disable iff (rst)
    (acc.capture_value_access[1] && st_q.armed.capture_flag[1] && !cap_hit[1])
      |=> !st_q.flags.capture_flag[1])
    else $error("capture two flag not cleared");

  chk_compare_hold: assert property (@(posedge clk) disable iff (rst)
    !acc.compare_value_write[0] |=> $stable(compare_value_one))
    else $error("compare one value changed without a write");

  chk_pin_disabled: assert property (@(posedge clk) disable iff (rst)
    (cmp_hit[1] && !ctrl.compare_pin_enable[1]) |=> $stable(compare_output_two))
    else $error("disabled compare two pin changed on match");

  chk_overflow_clear: assert property (@(posedge clk) disable iff (rst)
    (acc.main_count_access && st_q.armed.overflow_flag && !(tick && st_q.cnt == TCC_CNT_MAX))
      |=> !st_q.flags.overflow_flag)
    else $error("overflow flag not cleared after main count access");

  chk_capture_one: assert property (@(posedge clk) disable iff (rst)
    cap_hit[0] |=> capture_value_one == $past(st_q.cnt))
    else $error("capture one not latched");

  chk_irq_capture: assert property (@(posedge clk) disable iff (rst)
    (ctrl.capture_irq_enable && |st_q.flags.capture_flag && !cpu_irq_mask) |-> timer_irq)
    else $error("pending capture irq not raised");

  chk_irq_compare: assert property (@(posedge clk) disable iff (rst)
    (ctrl.compare_irq_enable && |st_q.flags.compare_flag && !cpu_irq_mask) |-> timer_irq)
    else $error("pending compare irq not raised");

endmodule : tcc_core

/* File: tcc_pins.sv */
// partner model: capture pin sources on the far side of the timer
`timescale 1ns/1ps
module tcc_pins (
  input  wire logic clk,
  output logic      cap_one,
  output logic      cap_two
);
  // ======================================
  // pin drive
  // idle at opposite levels so both edge kinds can be made
  initial
  begin
    cap_one = 1'b1;
    cap_two = 1'b0;
  end
  // one level change just after an edge, held until the next call
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk);
    #1;
    if (ch == 1) cap_one = v;
    else cap_two = v;
  endtask : set_pin
endmodule : tcc_pins

/* File: tcc_core_test.sv */
// testbench: directed scenarios for the capture/compare timer
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module tcc_core_test;
  import tcc_pkg::*;
  logic clk, rst, osc, mask, halt, waitm, cap1, cap2, c_one, c_two, irq;
  tcc_ctrl_t ctrl;
  tcc_acc_t acc;
  tcc_flags_t flg;
  logic [7:0] wd, cnt, alt, cv1, cv2, cp1, cp2, c;
  logic [1:0] drv;
  int error_cnt, n_checks, cyc;
  // ======================================
  // clock, reset and instances
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  tcc_pins i_tcc_pins (.clk(clk), .cap_one(cap1), .cap_two(cap2));
  // short slow divider keeps the div8000 path testable in a short run
  tcc_core #(.SLOW_DIV(4)) i_tcc_core (
    .clk(clk), .rst(rst), .ctrl(ctrl), .acc(acc), .compare_wdata(wd), .osc_tick(osc),
    .cpu_irq_mask(mask), .halt_mode(halt), .wait_mode(waitm),
    .capture_input_one(cap1), .capture_input_two(cap2), .main_count_register(cnt),
    .alternate_count_register(alt), .capture_value_one(cv1), .capture_value_two(cv2),
    .compare_value_one(cp1), .compare_value_two(cp2), .timer_status_register(flg),
    .compare_output_one(c_one), .compare_output_two(c_two),
    .compare_output_drive(drv), .timer_irq(irq));
  // ======================================
  // helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // strobe lasts one cycle, then one idle cycle so strobes never merge
  task automatic pulse(input tcc_acc_t a);
    acc = a;
    step(1);
    acc = '0;
    step(1);
  endtask : pulse
  task automatic osc_ticks(input int n);
    repeat (n)
    begin
      osc = 1'b1;
      step(1);
      osc = 1'b0;
      step(1);
    end
  endtask : osc_ticks
  task automatic wait_move();
    c = cnt;
    for (int k = 0; k < 40 && cnt === c; k++) step(1);
  endtask : wait_move
  // ======================================
  // scenarios
  task automatic t_reset();
    `CHK(cnt, TCC_CNT_RESET)
    `CHK({cp1, cp2}, {TCC_CMP_RESET, TCC_CMP_RESET})
    `CHK({flg, c_one, c_two, irq}, 8'h00)
    $display("test reset done");
  endtask : t_reset
  task automatic t_count();
    ctrl.clock_select_field = TCC_CS_DIV2;
    waitm = 1'b1;
    wait_move();
    c = cnt;
    step(2);
    `CHK(cnt, c + TCC_ONE)
    for (int k = 0; k < 600 && cnt !== 8'h00; k++) step(1);
    step(1);
    `CHK(flg.overflow_flag, 1'b1)
    ctrl.overflow_irq_enable = 1'b1;
    mask = 1'b1;
    step(1);
    `CHK(irq, 1'b0)
    mask = 1'b0;
    step(1);
    `CHK(irq, 1'b1)
    ctrl.clock_select_field = TCC_CS_DIV8;
    pulse('{main_count_access: 1'b1, default: '0});
    `CHK(flg.overflow_flag, 1'b1)
    pulse('{status_read: 1'b1, default: '0});
    pulse('{alt_count_write: 1'b1, default: '0});
    `CHK({flg.overflow_flag, cnt, alt}, {1'b1, TCC_CNT_RESET, TCC_CNT_RESET})
    pulse('{main_count_access: 1'b1, default: '0});
    `CHK(flg.overflow_flag, 1'b0)
    ctrl.overflow_irq_enable = 1'b0;
    halt = 1'b1;
    step(1);
    c = cnt;
    step(40);
    `CHK(cnt, c)
    halt = 1'b0;
    wait_move();
    `CHK(cnt, c + TCC_ONE)
    $display("test count done");
  endtask : t_count
  task automatic t_capture();
    ctrl.clock_select_field = TCC_CS_DIV8000;
    ctrl.capture_edge_select = 2'b10;
    ctrl.capture_irq_enable = 1'b1;
    pulse('{main_count_write: 1'b1, main_count_access: 1'b1, default: '0});
    i_tcc_pins.set_pin(2, 1'b1);
    step(5);
    `CHK({cv2, flg.capture_flag[1], irq}, {TCC_CNT_RESET, 2'b11})
    osc_ticks(4);
    `CHK(cnt, 8'hFD)
    i_tcc_pins.set_pin(2, 1'b0);
    step(5);
    `CHK(cv2, TCC_CNT_RESET)
    ctrl.single_pulse_mode = 1'b1;
    i_tcc_pins.set_pin(1, 1'b0);
    step(5);
    `CHK(flg.capture_flag[0], 1'b0)
    ctrl.single_pulse_mode = 1'b0;
    i_tcc_pins.set_pin(1, 1'b1);
    i_tcc_pins.set_pin(1, 1'b0);
    step(5);
    `CHK({flg.capture_flag[0], cv1}, {1'b1, 8'hFD})
    i_tcc_pins.set_pin(2, 1'b1);
    step(5);
    `CHK(cv2, 8'hFD)
    pulse('{status_read: 1'b1, default: '0});
    pulse('{capture_value_access: 2'b10, default: '0});
    `CHK(flg.capture_flag, 2'b01)
    ctrl.capture_irq_enable = 1'b0;
    $display("test capture done");
  endtask : t_capture
  task automatic t_compare();
    wd = 8'hFD;
    pulse('{compare_value_write: 2'b11, compare_value_access: 2'b11, default: '0});
    `CHK({cp1, cp2}, 16'hFDFD)
    ctrl.compare_pin_enable = 2'b01;
    ctrl.output_level = 2'b11;
    ctrl.compare_irq_enable = 1'b1;
    pulse('{main_count_write: 1'b1, main_count_access: 1'b1, default: '0});
    osc_ticks(4);
    `CHK({cnt, flg.compare_flag}, {8'hFD, 2'b00})
    osc_ticks(4);
    step(1);
    `CHK({flg.compare_flag, c_one, c_two, drv}, 6'b111001)
    `CHK(irq, 1'b1)
    pulse('{status_read: 1'b1, default: '0});
    pulse('{compare_value_access: 2'b01, default: '0});
    `CHK(flg.compare_flag, 2'b10)
    ctrl.compare_irq_enable = 1'b0;
    ctrl.output_level = 2'b00;
    pulse('{force_output_write: 2'b01, default: '0});
    `CHK({c_one, flg.compare_flag}, 3'b010)
    ctrl.output_level = 2'b01;
    ctrl.pwm_mode = 1'b1;
    pulse('{force_output_write: 2'b01, default: '0});
    `CHK(c_one, 1'b0)
    ctrl.pwm_mode = 1'b0;
    $display("test compare done");
  endtask : t_compare
  // reset taken while halted, then a div2 match and a rewrite of the compare value
  task automatic t_restart();
    halt = 1'b1;
    rst = 1'b1;
    step(2);
    halt = 1'b0;
    rst = 1'b0;
    step(1);
    `CHK({cnt, cp2, flg}, {TCC_CNT_RESET, TCC_CMP_RESET, 5'h00})
    ctrl.clock_select_field = TCC_CS_DIV2;
    ctrl.output_level = 2'b00;
    wd = 8'h02;
    pulse('{compare_value_write: 2'b10, default: '0});
    for (int k = 0; k < 40 && flg.compare_flag[1] !== 1'b1; k++) step(1);
    `CHK(cnt, wd)
    wd = 8'h05;
    pulse('{compare_value_write: 2'b10, default: '0});
    `CHK(cp2, wd)
    $display("test restart done");
  endtask : t_restart
  // ======================================
  // watchdog and main sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    rst = 1'b1;
    ctrl = '0;
    acc = '0;
    wd = 8'h00;
    osc = 1'b0;
    mask = 1'b0;
    halt = 1'b0;
    waitm = 1'b0;
    step(3);
    rst = 1'b0;
    step(1);
    t_reset();
    t_count();
    t_capture();
    t_compare();
    t_restart();
    end_sim();
  end
endmodule : tcc_core_test
